// ===== inc/tx_ctrl_pkg.sv
// Register indices, field positions and reset values of the transmit control bank
package tx_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_NORMAL_CTL = 6'h1b;
  localparam logic [5:0] IDX_SLOT1_CTL = 6'h1c;
  localparam logic [5:0] IDX_SLOT2_CTL = 6'h1d;
  localparam logic [5:0] IDX_END_23 = 6'h1e;
  localparam logic [5:0] IDX_END_45 = 6'h1f;
  localparam logic [5:0] IDX_END_6 = 6'h20;
  localparam logic [5:0] IDX_PEND_SPACE = 6'h21;
  localparam logic [5:0] IDX_WAKE = 6'h22;
  localparam logic [5:0] IDX_NORMAL_STAT = 6'h30;

  // Field positions
  localparam int POS_TRIG = 0;
  localparam int POS_SEC = 1;
  localparam int POS_ACK = 2;
  localparam int POS_INDIRECT = 3;
  localparam int POS_RX_PEND = 4;
  localparam int POS_SLOT_LO = 3;
  localparam int POS_RETRY_LO = 6;
  localparam int POS_SPACE_LO = 2;
  localparam int POS_ALTERNATE = 1;
  localparam int POS_ACK_PEND = 0;
  localparam int POS_INSTANT = 7;
  localparam int POS_REG_WAKE = 6;
  localparam int POS_FAILED = 0;

  // Values after reset
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_END = 8'h00;
  localparam logic [5:0] RST_LONG_SPACE = 6'h21;
  localparam logic [7:0] RST_PEND_SPACE = {RST_LONG_SPACE, 2'b00};
  localparam logic [7:0] RST_WAKE = 8'h00;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== src/tx_fifo_gts_control_regs.sv
// Transmit path control and configuration register bank behind an AXI4-Lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Normal trigger write sends frame, self-clears
// - Status bit mirrors pending flag of received ack
// - Indirect bit enables coordinator indirect transmission
// - Ack request bit asks ack, retransmits otherwise
// - Security bit secures the normal FIFO frame
// - Normal control bits clear at next trigger
// - Slot1 retry: write sets, read returns used
// - Three-bit slot select at bits five to three
// - Slot1 ack, security, self-clearing send trigger
// - Slot2 control repeats slot1 layout and behaviour
// - Slot2 trigger sends frame, clears itself
// - Four-bit end slots for slots two to six
// - Long spacing field, reset value 0x21
// - Alternate bit keeps slot FIFOs toggling
// - Pending setting copied into sent acks
// - Instant wake enable bit selects wake mode
// - Six-bit beacon start interval, reset zero
// - Normal retries and failure reported in status
module tx_fifo_gts_control_regs
  import tx_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Results from the transmit engine
  input wire logic ack_rx_done,
  input wire logic ack_rx_pending,
  input wire logic normal_done,
  input wire logic [1:0] normal_retries,
  input wire logic normal_failed,
  input wire logic slot1_done,
  input wire logic [1:0] slot1_retries,
  input wire logic slot2_done,
  input wire logic [1:0] slot2_retries,
  // Normal FIFO launch
  output logic normal_send_trigger,
  output logic normal_indirect,
  output logic normal_ack_request,
  output logic normal_security_enable,
  // Slot FIFO launch and settings
  output logic slot1_send_trigger,
  output logic [1:0] slot1_retry_count,
  output logic [2:0] slot1_slot_select,
  output logic slot1_ack_request,
  output logic slot1_security_enable,
  output logic slot2_send_trigger,
  output logic [1:0] slot2_retry_count,
  output logic [2:0] slot2_slot_select,
  output logic slot2_ack_request,
  output logic slot2_security_enable,
  // Slot end positions
  output logic [3:0] second_slot_end,
  output logic [3:0] third_slot_end,
  output logic [3:0] fourth_slot_end,
  output logic [3:0] fifth_slot_end,
  output logic [3:0] sixth_slot_end,
  // Spacing, pending and wake settings
  output logic [5:0] long_spacing_symbols,
  output logic slot_fifo_alternate,
  output logic ack_pending_setting,
  output logic instant_wake_enable,
  output logic register_wake_pulse,
  output logic [5:0] beacon_start_interval
);

  import tx_ctrl_pkg::*;

  // Bus slave state; readies are flops of their own so the outputs stay registered
  logic awready_q;
  logic wready_q;
  logic arready_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;

  // Register state
  logic [3:1] normal_ctl_q;
  logic rx_pend_q;
  logic normal_go_q;
  logic normal_ind_sent_q;
  logic normal_ack_sent_q;
  logic normal_sec_sent_q;
  logic [7:1] slot_ctl_q [2];
  logic [1:0] slot_go_q;
  logic [7:0] end23_q;
  logic [7:0] end45_q;
  logic [3:0] end6_q;
  logic [7:0] pend_space_q;
  logic [7:0] wake_q;
  logic [1:0] stat_retry_q;
  logic stat_failed_q;

  // Write and read decode; slot report wiring
  logic wr_go;
  logic [5:0] wr_idx;
  logic wr_mapped;
  logic [5:0] rd_idx;
  logic [7:0] rd_d;
  logic rd_mapped;
  logic [1:0] slot_done;
  logic [1:0] slot_ret [2];

  assign wr_go = ~awready_q & ~wready_q & ~bvalid_q;
  // Misaligned address decodes to no register, so it can never store
  assign wr_idx = (awaddr_q[1:0] == 2'b00) ? awaddr_q[7:2] : 6'h3f;
  assign rd_idx = s_axi_araddr[7:2];
  assign slot_done = {slot2_done, slot1_done};
  assign slot_ret[0] = slot1_retries;
  assign slot_ret[1] = slot2_retries;

  always_comb
  begin
    wr_mapped = (awaddr_q[1:0] == 2'b00) &&
                (wr_idx >= IDX_NORMAL_CTL && wr_idx <= IDX_WAKE);
  end

  function automatic logic wr_hit(input logic go, input logic lane,
                                  input logic [5:0] idx, input logic [5:0] want);
    wr_hit = go & lane & (idx == want);
  endfunction

  // Write address and data are captured independently, either order
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        awready_q <= 1'b1;
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      else if (wr_go)
        wready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;

  // Write response is raised at the same clock edge as the register update
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Normal FIFO control; settings are handed over at trigger, then cleared
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      normal_ctl_q <= RST_CTL[3:1];
      normal_go_q <= 1'b0;
      normal_ind_sent_q <= 1'b0;
      normal_ack_sent_q <= 1'b0;
      normal_sec_sent_q <= 1'b0;
    end
    else if (wr_hit(wr_go, wlane_q, wr_idx, IDX_NORMAL_CTL) && wdata_q[POS_TRIG])
    begin
      normal_go_q <= 1'b1;
      normal_ind_sent_q <= wdata_q[POS_INDIRECT];
      normal_ack_sent_q <= wdata_q[POS_ACK];
      normal_sec_sent_q <= wdata_q[POS_SEC];
      normal_ctl_q <= 3'b000;
    end
    else
    begin
      normal_go_q <= 1'b0;
      if (wr_hit(wr_go, wlane_q, wr_idx, IDX_NORMAL_CTL))
        normal_ctl_q <= wdata_q[3:1];
    end
  end

  assign normal_send_trigger = normal_go_q;
  assign normal_indirect = normal_ind_sent_q;
  assign normal_ack_request = normal_ack_sent_q;
  assign normal_security_enable = normal_sec_sent_q;

  // Pending flag of the last received acknowledgement
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rx_pend_q <= 1'b0;
    else if (ack_rx_done)
      rx_pend_q <= ack_rx_pending;
  end

  // Normal FIFO result for software
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stat_retry_q <= 2'b00;
      stat_failed_q <= 1'b0;
    end
    else if (normal_done)
    begin
      stat_retry_q <= normal_retries;
      stat_failed_q <= normal_failed;
    end
  end

  // Both slot FIFOs share one layout
  for (genvar g = 0; g < 2; g++)
  begin : g_slot
    localparam logic [5:0] IDX = IDX_SLOT1_CTL + 6'(g);
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        slot_ctl_q[g] <= RST_CTL[7:1];
        slot_go_q[g] <= 1'b0;
      end
      else
      begin
        // Zero in the trigger bit never cancels a launch
        slot_go_q[g] <= wr_hit(wr_go, wlane_q, wr_idx, IDX) & wdata_q[POS_TRIG];
        if (wr_hit(wr_go, wlane_q, wr_idx, IDX))
          slot_ctl_q[g] <= wdata_q[7:1];
        // Engine report wins over a same-cycle write
        if (slot_done[g])
          slot_ctl_q[g][7:6] <= slot_ret[g];
      end
    end
  end

  assign slot1_send_trigger = slot_go_q[0];
  assign slot1_retry_count = slot_ctl_q[0][7:6];
  assign slot1_slot_select = slot_ctl_q[0][5:3];
  assign slot1_ack_request = slot_ctl_q[0][POS_ACK];
  assign slot1_security_enable = slot_ctl_q[0][POS_SEC];
  assign slot2_send_trigger = slot_go_q[1];
  assign slot2_retry_count = slot_ctl_q[1][7:6];
  assign slot2_slot_select = slot_ctl_q[1][5:3];
  assign slot2_ack_request = slot_ctl_q[1][POS_ACK];
  assign slot2_security_enable = slot_ctl_q[1][POS_SEC];

  // Slot end positions
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      end23_q <= RST_END;
      end45_q <= RST_END;
      end6_q <= RST_END[3:0];
    end
    else
    begin
      if (wr_hit(wr_go, wlane_q, wr_idx, IDX_END_23))
        end23_q <= wdata_q;
      if (wr_hit(wr_go, wlane_q, wr_idx, IDX_END_45))
        end45_q <= wdata_q;
      if (wr_hit(wr_go, wlane_q, wr_idx, IDX_END_6))
        end6_q <= wdata_q[3:0];
    end
  end

  assign second_slot_end = end23_q[3:0];
  assign third_slot_end = end23_q[7:4];
  assign fourth_slot_end = end45_q[3:0];
  assign fifth_slot_end = end45_q[7:4];
  assign sixth_slot_end = end6_q;

  // Spacing, pending and wake settings
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pend_space_q <= RST_PEND_SPACE;
      wake_q <= RST_WAKE;
    end
    else
    begin
      if (wr_hit(wr_go, wlane_q, wr_idx, IDX_PEND_SPACE))
        pend_space_q <= wdata_q;
      if (wr_hit(wr_go, wlane_q, wr_idx, IDX_WAKE))
        wake_q <= wdata_q;
    end
  end

  assign long_spacing_symbols = pend_space_q[7:2];
  assign slot_fifo_alternate = pend_space_q[POS_ALTERNATE];
  assign ack_pending_setting = pend_space_q[POS_ACK_PEND];
  assign instant_wake_enable = wake_q[POS_INSTANT];
  assign register_wake_pulse = wake_q[POS_REG_WAKE];
  assign beacon_start_interval = wake_q[5:0];

  // Read mux; trigger and reserved bits read as zero
  always_comb
  begin
    rd_d = 8'h00;
    rd_mapped = (s_axi_araddr[1:0] == 2'b00);
    unique case (rd_idx)
      IDX_NORMAL_CTL: rd_d = {3'b000, rx_pend_q, normal_ctl_q, 1'b0};
      IDX_SLOT1_CTL: rd_d = {slot_ctl_q[0], 1'b0};
      IDX_SLOT2_CTL: rd_d = {slot_ctl_q[1], 1'b0};
      IDX_END_23: rd_d = end23_q;
      IDX_END_45: rd_d = end45_q;
      IDX_END_6: rd_d = {4'h0, end6_q};
      IDX_PEND_SPACE: rd_d = pend_space_q;
      IDX_WAKE: rd_d = wake_q;
      IDX_NORMAL_STAT: rd_d = {stat_retry_q, 5'h00, stat_failed_q};
      default: rd_mapped = 1'b0;
    endcase
  end

  // One read at a time; data held until taken
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
      rdata_q <= 8'h00;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      rvalid_q <= 1'b1;
      arready_q <= 1'b0;
      rdata_q <= rd_mapped ? rd_d : 8'h00;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;

  // Checks
  logic normal_wr;
  assign normal_wr = wr_hit(wr_go, wlane_q, wr_idx, IDX_NORMAL_CTL);

  sequence seq_normal_launch;
    normal_wr && wdata_q[POS_TRIG];
  endsequence

  sequence seq_one_pulse(logic sig);
    sig ##1 !sig;
  endsequence

  a_normal_trig_pulse: assert property (@(posedge core_clk) disable iff (srst)
    seq_normal_launch |=> seq_one_pulse(normal_send_trigger))
    else $error("normal trigger not a single pulse after write");

  a_trig_zero_idle: assert property (@(posedge core_clk) disable iff (srst)
    (normal_wr && !wdata_q[POS_TRIG]) |=> !normal_send_trigger)
    else $error("zero write launched the normal FIFO");

  a_settings_clear: assert property (@(posedge core_clk) disable iff (srst)
    seq_normal_launch |=> (normal_ctl_q == 3'b000) &&
      (normal_ack_request == $past(wdata_q[POS_ACK])))
    else $error("normal settings not handed over and cleared");

  a_rx_pend_track: assert property (@(posedge core_clk) disable iff (srst)
    ack_rx_done |=> rx_pend_q == $past(ack_rx_pending))
    else $error("pending status does not follow received ack");

  a_slot_retry_report: assert property (@(posedge core_clk) disable iff (srst)
    slot1_done |=> slot1_retry_count == $past(slot1_retries))
    else $error("slot1 retry count not updated");

  a_slot2_trig_pulse: assert property (@(posedge core_clk) disable iff (srst)
    (wr_hit(wr_go, wlane_q, wr_idx, IDX_SLOT2_CTL) && wdata_q[POS_TRIG])
      |=> seq_one_pulse(slot2_send_trigger))
    else $error("slot2 trigger not a single pulse");

  a_spacing_reset: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> long_spacing_symbols == RST_LONG_SPACE)
    else $error("long spacing reset value wrong");

  a_status_report: assert property (@(posedge core_clk) disable iff (srst)
    normal_done |=> (stat_retry_q == $past(normal_retries)) &&
      (stat_failed_q == $past(normal_failed)))
    else $error("normal status not reported");

  a_bresp_after_write: assert property (@(posedge core_clk) disable iff (srst)
    wr_go |=> s_axi_bvalid && (s_axi_bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR)))
    else $error("no write response after write");

  a_end6_write: assert property (@(posedge core_clk) disable iff (srst)
    wr_hit(wr_go, wlane_q, wr_idx, IDX_END_6) |=> sixth_slot_end == $past(wdata_q[3:0]))
    else $error("sixth slot end not stored");

endmodule

`default_nettype wire

// ===== test/tx_engine_model.sv
// Behavioural transmit engine answering each launch with a completion report
`timescale 1ns/100ps
`default_nettype none
module tx_engine_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Launches and scripted outcome
  input wire logic normal_send_trigger,
  input wire logic slot1_send_trigger,
  input wire logic slot2_send_trigger,
  input wire logic [1:0] rep_retries,
  input wire logic rep_fail,
  input wire logic rep_pend,
  // Completion reports
  output logic ack_rx_done,
  output logic ack_rx_pending,
  output logic normal_done,
  output logic [1:0] normal_retries,
  output logic normal_failed,
  output logic slot1_done,
  output logic [1:0] slot1_retries,
  output logic slot2_done,
  output logic [1:0] slot2_retries
);
  logic [3:0] n_q;
  logic [3:0] g1_q;
  logic [3:0] g2_q;
  // Fixed air time keeps the bench waits short
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      n_q <= 4'h0;
      g1_q <= 4'h0;
      g2_q <= 4'h0;
    end
    else
    begin
      n_q <= {n_q[2:0], normal_send_trigger};
      g1_q <= {g1_q[2:0], slot1_send_trigger};
      g2_q <= {g2_q[2:0], slot2_send_trigger};
    end
  end
  // Outside a report the qualifiers show junk, so stale values cannot pass
  assign normal_done = n_q[3];
  assign normal_retries = normal_done ? rep_retries : ~rep_retries;
  assign normal_failed = normal_done ? rep_fail : ~rep_fail;
  assign ack_rx_done = n_q[3];
  assign ack_rx_pending = ack_rx_done ? rep_pend : ~rep_pend;
  assign slot1_done = g1_q[3];
  assign slot1_retries = slot1_done ? rep_retries : ~rep_retries;
  assign slot2_done = g2_q[3];
  assign slot2_retries = slot2_done ? rep_retries : ~rep_retries;
endmodule
`default_nettype wire

// ===== test/tx_fifo_gts_control_regs_tb.sv
// Self-checking bench for the transmit control register bank
`timescale 1ns/100ps
`default_nettype none
module tx_fifo_gts_control_regs_tb;
  import tx_ctrl_pkg::*;
  logic core_clk, srst, rep_fail, rep_pend;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rep_retries;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ack_rx_done, ack_rx_pending, normal_done, normal_failed, slot1_done, slot2_done;
  logic [1:0] normal_retries, slot1_retries, slot2_retries;
  logic normal_send_trigger, normal_indirect, normal_ack_request, normal_security_enable;
  logic slot1_send_trigger, slot1_ack_request, slot1_security_enable;
  logic slot2_send_trigger, slot2_ack_request, slot2_security_enable;
  logic [1:0] slot1_retry_count, slot2_retry_count;
  logic [2:0] slot1_slot_select, slot2_slot_select;
  logic [3:0] second_slot_end, third_slot_end, fourth_slot_end, fifth_slot_end, sixth_slot_end;
  logic [5:0] long_spacing_symbols, beacon_start_interval;
  logic slot_fifo_alternate, ack_pending_setting, instant_wake_enable, register_wake_pulse;
  int fails, total_checks, cycles;
  int n_trig [3];

  tx_fifo_gts_control_regs #(.ADDR_W(8)) u_tx_fifo_gts_control_regs (
    .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ack_rx_done, .ack_rx_pending, .normal_done,
    .normal_retries, .normal_failed, .slot1_done, .slot1_retries, .slot2_done,
    .slot2_retries, .normal_send_trigger, .normal_indirect, .normal_ack_request,
    .normal_security_enable, .slot1_send_trigger, .slot1_retry_count, .slot1_slot_select,
    .slot1_ack_request, .slot1_security_enable, .slot2_send_trigger, .slot2_retry_count,
    .slot2_slot_select, .slot2_ack_request, .slot2_security_enable, .second_slot_end,
    .third_slot_end, .fourth_slot_end, .fifth_slot_end, .sixth_slot_end,
    .long_spacing_symbols, .slot_fifo_alternate, .ack_pending_setting,
    .instant_wake_enable, .register_wake_pulse, .beacon_start_interval);

  tx_engine_model u_tx_engine_model (
    .core_clk, .srst, .normal_send_trigger, .slot1_send_trigger, .slot2_send_trigger,
    .rep_retries, .rep_fail, .rep_pend, .ack_rx_done, .ack_rx_pending, .normal_done,
    .normal_retries, .normal_failed, .slot1_done, .slot1_retries, .slot2_done,
    .slot2_retries);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Counting high cycles also catches a trigger that stays up too long
  always @(posedge core_clk)
  begin
    if (normal_send_trigger === 1'b1)
      n_trig[0]++;
    if (slot1_send_trigger === 1'b1)
      n_trig[1]++;
    if (slot2_send_trigger === 1'b1)
      n_trig[2]++;
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ends at the falling edge where the response is seen; bready is always up
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever
    begin
      @(negedge core_clk);
      if (s_axi_bvalid === 1'b1)
        break;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge core_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    chk(s_axi_bresp, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge core_clk);
    while (s_axi_arready !== 1'b1)
      @(negedge core_clk);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    @(negedge core_clk);
    while (s_axi_rvalid !== 1'b1)
      @(negedge core_clk);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  task automatic t_reset();
    logic [7:0] rv [8];
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h00};
    for (int i = 0; i < 8; i++)
      rd_chk({IDX_NORMAL_CTL + 6'(i), 2'b00}, {24'h0, rv[i]}, RESP_OKAY);
    rd_chk({IDX_NORMAL_STAT, 2'b00}, 32'h0, RESP_OKAY);
    chk({long_spacing_symbols, beacon_start_interval, instant_wake_enable}, 13'h1080);
  endtask

  task automatic t_config();
    logic [5:0] ix [5];
    logic [7:0] wd [5];
    logic [7:0] rb [5];
    ix = '{IDX_END_23, IDX_END_45, IDX_END_6, IDX_PEND_SPACE, IDX_WAKE};
    wd = '{8'ha5, 8'h3c, 8'h0f, 8'h7f, 8'hc5};
    rb = '{8'ha5, 8'h3c, 8'h0f, 8'h7f, 8'hc5};
    for (int i = 0; i < 5; i++)
    begin
      wr_chk({ix[i], 2'b00}, wd[i], RESP_OKAY);
      rd_chk({ix[i], 2'b00}, {24'h0, rb[i]}, RESP_OKAY);
    end
    chk({second_slot_end, third_slot_end, fourth_slot_end, fifth_slot_end,
         sixth_slot_end}, 20'h5ac3f);
    chk({long_spacing_symbols, slot_fifo_alternate, ack_pending_setting}, 8'h7f);
    chk({instant_wake_enable, register_wake_pulse, beacon_start_interval}, 8'hc5);
    wr_chk({IDX_WAKE, 2'b00}, 8'h05, RESP_OKAY);
    chk({instant_wake_enable, register_wake_pulse, beacon_start_interval}, 8'h05);
  endtask

  task automatic t_normal();
    @(posedge core_clk);
    rep_retries <= 2'd2;
    rep_fail <= 1'b1;
    rep_pend <= 1'b1;
    wr_chk({IDX_NORMAL_CTL, 2'b00}, 8'h0f, RESP_OKAY);
    chk({normal_indirect, normal_ack_request, normal_security_enable}, 3'b111);
    repeat (8) @(negedge core_clk);
    chk(n_trig[0], 1);
    rd_chk({IDX_NORMAL_CTL, 2'b00}, 32'h10, RESP_OKAY);
    rd_chk({IDX_NORMAL_STAT, 2'b00}, 32'h81, RESP_OKAY);
    @(posedge core_clk);
    rep_pend <= 1'b0;
    wr_chk({IDX_NORMAL_CTL, 2'b00}, 8'h01, RESP_OKAY);
    chk({normal_indirect, normal_ack_request, normal_security_enable}, 3'b000);
    wr_chk({IDX_NORMAL_CTL, 2'b00}, 8'h00, RESP_OKAY);
    repeat (8) @(negedge core_clk);
    chk(n_trig[0], 2);
    rd_chk({IDX_NORMAL_CTL, 2'b00}, 32'h00, RESP_OKAY);
  endtask

  task automatic t_slots();
    logic [5:0] ix;
    @(posedge core_clk);
    rep_retries <= 2'd1;
    for (int i = 0; i < 2; i++)
    begin
      ix = IDX_SLOT1_CTL + 6'(i);
      wr_chk({ix, 2'b00}, 8'hef, RESP_OKAY);
      chk(i ? {slot2_slot_select, slot2_ack_request, slot2_security_enable} :
              {slot1_slot_select, slot1_ack_request, slot1_security_enable}, 5'h17);
      chk(i ? slot2_retry_count : slot1_retry_count, 2'd3);
      repeat (8) @(negedge core_clk);
      chk(n_trig[1 + i], 1);
      rd_chk({ix, 2'b00}, 32'h6e, RESP_OKAY);
    end
  endtask

  task automatic t_unmapped();
    wr_chk(8'h68, 8'hff, RESP_SLVERR);
    wr_chk(8'h79, 8'h11, RESP_SLVERR);
    rd_chk(8'h8c, 32'h0, RESP_SLVERR);
    // Lane 0 strobe low: answered, but nothing stored
    @(posedge core_clk);
    s_axi_wstrb <= 4'h0;
    wr_chk({IDX_END_23, 2'b00}, 8'h11, RESP_OKAY);
    @(posedge core_clk);
    s_axi_wstrb <= 4'h1;
    rd_chk({IDX_END_23, 2'b00}, 32'ha5, RESP_OKAY);
  endtask

  initial
  begin
    srst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    rep_retries = 2'd0;
    rep_fail = 1'b0;
    rep_pend = 1'b0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_normal();
    t_slots();
    t_unmapped();
    final_report();
  end
endmodule
`default_nettype wire
